// ### rtl/canopen_app_pkg.sv
// constants and types for the application object handler
package canopen_app_pkg;

    // --------------------------------------------------------------
    // object indices
    // --------------------------------------------------------------
    localparam logic [15:0] IDX_DEMUX = 16'h3005;
    localparam logic [15:0] IDX_PCT_SET = 16'h3006;
    localparam logic [15:0] IDX_PCT_ACT = 16'h3007;
    localparam logic [15:0] IDX_MOTION_BLOCK = 16'h5FF0;
    localparam logic [15:0] IDX_ABORT_OPT = 16'h6007;
    localparam logic [15:0] IDX_ERROR_CODE = 16'h603F;

    // --------------------------------------------------------------
    // source numbers and settings
    // --------------------------------------------------------------
    localparam logic [9:0] SRC_DEMUX_FIRST = 10'h340;
    localparam logic [9:0] SRC_DEMUX_LAST = 10'h34F;
    localparam logic [9:0] SRC_PCT_SET = 10'h32F;
    localparam logic [9:0] SRC_PCT_ACT_RESET = 10'h034;
    localparam logic [15:0] ABORT_OPT_RESET = 16'h0001;
    localparam logic [2:0] ERR_BEHAV_RESET = 3'h1;
    localparam logic [1:0] REMOTE_STATE_MACHINE = 2'h1;
    localparam logic [7:0] MODE_TABLE_TRAVEL = 8'hFF;

    // --------------------------------------------------------------
    // profile error codes
    // --------------------------------------------------------------
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_GENERIC = 16'h1000;
    localparam logic [15:0] ERR_OVERLOAD = 16'h2310;
    localparam logic [15:0] ERR_CASE_TEMP = 16'h4210;
    localparam logic [15:0] ERR_INSIDE_TEMP = 16'h4110;
    localparam logic [15:0] ERR_MOTOR_TEMP = 16'h4310;
    localparam logic [15:0] ERR_PHASE_OC = 16'h2340;
    localparam logic [15:0] ERR_DC_LINK = 16'h3210;
    localparam logic [15:0] ERR_SUPPLY = 16'h5111;
    localparam logic [15:0] ERR_EARTH = 16'h2330;

    typedef enum logic [3:0] {
        FC_NONE = 4'h0,
        FC_OVERLOAD = 4'h1,
        FC_CASE_TEMP = 4'h2,
        FC_INSIDE_TEMP = 4'h3,
        FC_MOTOR_TEMP = 4'h4,
        FC_PHASE_OC = 4'h5,
        FC_DC_LINK = 4'h7,
        FC_SUPPLY = 4'h8,
        FC_EARTH = 4'hD
    } fault_class_t;

    typedef enum logic [2:0] {
        ACT_NONE = 3'h0,
        ACT_FAULT = 3'h1,
        ACT_DISABLE_VOLTAGE = 3'h2,
        ACT_QUICK_STOP = 3'h3,
        ACT_RAMP_THEN_FAULT = 3'h4,
        ACT_QSTOP_THEN_FAULT = 3'h5
    } loss_action_t;

    typedef enum logic [1:0] {
        LS_IDLE = 2'b00,
        LS_STOPPING = 2'b01,
        LS_LATCHED = 2'b10
    } loss_state_t;

endpackage : canopen_app_pkg

// ### rtl/canopen_app_object_handler.sv
// application object handler: demux, percentage, abort option, error code
`timescale 1ns/1ps
module canopen_app_object_handler (
    input wire logic sys_clk,
    input wire logic rst,

    // object access
    input wire logic obj_wr,
    input wire logic obj_rd,
    input wire logic [15:0] obj_index,
    input wire logic [15:0] obj_wdata,
    output logic [15:0] obj_rdata,
    output logic obj_ack,
    output logic obj_err,

    // internal error-behaviour setting access
    input wire logic setting_wr,
    input wire logic [2:0] setting_wdata,
    output logic [2:0] setting_value,

    // non-volatile store
    input wire logic save_cmd,
    input wire logic nv_restore,
    input wire logic nv_valid,
    input wire logic [15:0] nv_rdata,
    output logic nv_wr,
    output logic [15:0] nv_wdata,

    // application sources
    input wire logic [9:0] src_select,
    output logic src_bool,
    input wire logic [9:0] pct_act_source_wdata,
    input wire logic pct_act_source_wr,
    input wire logic [15:0] src_pct_value,
    output logic [9:0] pct_src_req,
    output logic [15:0] pct_set_out,
    output logic [15:0] demux_out,

    // motion
    input wire logic [7:0] modes_of_operation,
    input wire logic [15:0] motion_block_number,

    // bus events
    input wire logic bus_off,
    input wire logic guarding_fail,
    input wire logic heartbeat_fail,
    input wire logic sync_error,
    input wire logic rxpdo_valid,
    input wire logic rxpdo_len_ok,
    input wire logic nmt_operational,
    input wire logic guarding_running,
    input wire logic [1:0] local_remote,
    input wire logic drive_standstill,

    // drive state machine commands
    output logic cmd_fault,
    output logic cmd_disable_voltage,
    output logic cmd_quick_stop,
    output logic cmd_disable_operation,
    output logic rxpdo_accept,
    input wire logic fault_reset_req,
    output logic fault_reset_ok,

    // faults
    input wire logic fault_event,
    input wire logic [3:0] fault_class,
    input wire logic [15:0] fault_code,
    output logic [15:0] current_error,
    output logic [31:0] emcy_fault_bytes
);

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        logic [15:0] demux;
        logic [15:0] pct_set;
        logic [9:0] pct_sel;
        logic [2:0] behav;

        logic [15:0] err_code;
        logic [15:0] cur_err;
        logic [31:0] emcy;

        canopen_app_pkg::loss_state_t ls;
        canopen_app_pkg::loss_action_t act;
        logic left_op;
        logic guard_lost;
        logic pdo_block;
        logic nmt_q;

        logic [15:0] rdata;
        logic ack;
        logic err;

        logic nv_wr;
        logic [15:0] nv_data;
    } state_t;

    state_t s_q;
    state_t s_d;

    // setting 0..5 to signed object code
    function automatic logic [15:0] behav_to_code(input logic [2:0] b);
        case (b)
            3'h4: behav_to_code = 16'hFFFF;
            3'h5: behav_to_code = 16'hFFFE;
            default: behav_to_code = {13'h0000, b};
        endcase
    endfunction : behav_to_code

    // object code to setting; 3'h7 flags an illegal code
    function automatic logic [2:0] code_to_behav(input logic [15:0] c);
        case (c)
            16'h0000: code_to_behav = 3'h0;
            16'h0001: code_to_behav = 3'h1;
            16'h0002: code_to_behav = 3'h2;
            16'h0003: code_to_behav = 3'h3;
            16'hFFFF: code_to_behav = 3'h4;
            16'hFFFE: code_to_behav = 3'h5;
            default: code_to_behav = 3'h7;
        endcase
    endfunction : code_to_behav

    function automatic logic [15:0] class_to_code(input logic [3:0] fc);
        case (fc)
            canopen_app_pkg::FC_NONE: class_to_code = canopen_app_pkg::ERR_NONE;
            canopen_app_pkg::FC_OVERLOAD: class_to_code = canopen_app_pkg::ERR_OVERLOAD;
            canopen_app_pkg::FC_CASE_TEMP: class_to_code = canopen_app_pkg::ERR_CASE_TEMP;
            canopen_app_pkg::FC_INSIDE_TEMP: class_to_code = canopen_app_pkg::ERR_INSIDE_TEMP;
            canopen_app_pkg::FC_MOTOR_TEMP: class_to_code = canopen_app_pkg::ERR_MOTOR_TEMP;
            canopen_app_pkg::FC_PHASE_OC: class_to_code = canopen_app_pkg::ERR_PHASE_OC;
            canopen_app_pkg::FC_DC_LINK: class_to_code = canopen_app_pkg::ERR_DC_LINK;
            canopen_app_pkg::FC_SUPPLY: class_to_code = canopen_app_pkg::ERR_SUPPLY;
            canopen_app_pkg::FC_EARTH: class_to_code = canopen_app_pkg::ERR_EARTH;
            default: class_to_code = canopen_app_pkg::ERR_GENERIC;
        endcase
    endfunction : class_to_code

    // --------------------------------------------------------------
    // combinational helpers
    // --------------------------------------------------------------
    logic loss_event;
    logic nmt_leave;
    logic table_mode;
    logic [9:0] demux_idx;
    logic pdo_len_fail;

    assign nmt_leave = s_q.nmt_q && !nmt_operational;
    assign pdo_len_fail = rxpdo_valid && !rxpdo_len_ok;
    assign loss_event = bus_off
        || guarding_fail
        || heartbeat_fail
        || sync_error
        || pdo_len_fail
        || nmt_leave;
    assign table_mode = (modes_of_operation == canopen_app_pkg::MODE_TABLE_TRAVEL);
    assign demux_idx = src_select - canopen_app_pkg::SRC_DEMUX_FIRST;

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb begin
        logic [2:0] nb;
        nb = code_to_behav(obj_wdata);
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.err = 1'b0;
        s_d.nv_wr = 1'b0;
        s_d.nmt_q = nmt_operational;

        // object accesses
        if (obj_wr) begin
            s_d.ack = 1'b1;
            unique case (obj_index)
                canopen_app_pkg::IDX_DEMUX: begin
                    s_d.demux = obj_wdata;
                end
                canopen_app_pkg::IDX_PCT_SET: begin
                    s_d.pct_set = obj_wdata;
                end
                canopen_app_pkg::IDX_ABORT_OPT: begin
                    if (nb == 3'h7) begin
                        s_d.err = 1'b1;
                    end else begin
                        s_d.behav = nb;
                    end
                end
                default: s_d.err = 1'b1;
            endcase
        end else if (obj_rd) begin
            s_d.ack = 1'b1;
            s_d.rdata = 16'h0000;
            unique case (obj_index)
                canopen_app_pkg::IDX_DEMUX: begin
                    s_d.rdata = s_q.demux;
                end
                canopen_app_pkg::IDX_PCT_SET: begin
                    s_d.rdata = s_q.pct_set;
                end
                canopen_app_pkg::IDX_PCT_ACT: begin
                    s_d.rdata = src_pct_value;
                end
                canopen_app_pkg::IDX_MOTION_BLOCK: begin
                    if (table_mode) begin
                        s_d.rdata = motion_block_number;
                    end else begin
                        s_d.err = 1'b1;
                    end
                end
                canopen_app_pkg::IDX_ABORT_OPT: s_d.rdata = behav_to_code(s_q.behav);
                canopen_app_pkg::IDX_ERROR_CODE: s_d.rdata = s_q.err_code;
                default: s_d.err = 1'b1;
            endcase
        end

        if (setting_wr && setting_wdata <= 3'h5
            && !(obj_wr && obj_index == canopen_app_pkg::IDX_ABORT_OPT)) begin
            s_d.behav = setting_wdata;
        end

        if (pct_act_source_wr) begin
            s_d.pct_sel = pct_act_source_wdata;
        end

        // non-volatile store and restore
        if (save_cmd) begin
            s_d.nv_wr = 1'b1;
            s_d.nv_data = behav_to_code(s_q.behav);
        end

        if (nv_restore && nv_valid && code_to_behav(nv_rdata) != 3'h7) begin
            s_d.behav = code_to_behav(nv_rdata);
        end

        // fault recording
        if (fault_event) begin
            s_d.err_code = class_to_code(fault_class);
            s_d.cur_err = fault_code;
            s_d.emcy = {fault_code, 16'h0000};
        end

        // recovery preconditions
        if (nmt_leave && s_q.ls != canopen_app_pkg::LS_IDLE) begin
            s_d.left_op = 1'b1;
        end

        if (nmt_operational && !nmt_leave) begin
            s_d.left_op = 1'b0;
        end

        if (guarding_fail) begin
            s_d.guard_lost = 1'b1;
        end else if (guarding_running) begin
            s_d.guard_lost = 1'b0;
        end

        if (rxpdo_valid) begin
            s_d.pdo_block = !rxpdo_len_ok;
        end

        // connection-loss reaction
        unique case (s_q.ls)
            canopen_app_pkg::LS_IDLE: begin
                if (loss_event) begin
                    if (local_remote != canopen_app_pkg::REMOTE_STATE_MACHINE) begin
                        s_d.act = (s_q.behav == 3'h0) ? canopen_app_pkg::ACT_NONE
                            : canopen_app_pkg::ACT_FAULT;
                    end else begin
                        s_d.act = canopen_app_pkg::loss_action_t'(s_q.behav);
                    end
                    if (s_d.act == canopen_app_pkg::ACT_RAMP_THEN_FAULT
                        || s_d.act == canopen_app_pkg::ACT_QSTOP_THEN_FAULT) begin
                        s_d.ls = canopen_app_pkg::LS_STOPPING;
                    end else if (s_d.act != canopen_app_pkg::ACT_NONE) begin
                        s_d.ls = canopen_app_pkg::LS_LATCHED;
                    end
                    if (nmt_leave) begin
                        s_d.left_op = 1'b1;
                    end
                end
            end

            canopen_app_pkg::LS_STOPPING: begin
                if (drive_standstill) begin
                    s_d.act = canopen_app_pkg::ACT_FAULT;
                    s_d.ls = canopen_app_pkg::LS_LATCHED;
                end
            end

            canopen_app_pkg::LS_LATCHED: begin
                if (fault_reset_ok) begin
                    s_d.ls = canopen_app_pkg::LS_IDLE;
                    s_d.act = canopen_app_pkg::ACT_NONE;
                end
            end

            default: begin
                s_d.ls = canopen_app_pkg::LS_IDLE;
                s_d.act = canopen_app_pkg::ACT_NONE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.behav <= canopen_app_pkg::ERR_BEHAV_RESET;
            s_q.pct_sel <= canopen_app_pkg::SRC_PCT_ACT_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign obj_rdata = s_q.rdata;
    assign obj_ack = s_q.ack;
    assign obj_err = s_q.err;

    assign setting_value = s_q.behav;
    assign nv_wr = s_q.nv_wr;
    assign nv_wdata = s_q.nv_data;

    assign demux_out = s_q.demux;
    assign pct_set_out = s_q.pct_set;
    assign pct_src_req = s_q.pct_sel;
    assign src_bool = (src_select >= canopen_app_pkg::SRC_DEMUX_FIRST
        && src_select <= canopen_app_pkg::SRC_DEMUX_LAST)
        ? s_q.demux[demux_idx[3:0]] : 1'b0;

    // act none means option 0 holds the operating point
    assign cmd_fault = (s_q.act == canopen_app_pkg::ACT_FAULT);
    assign cmd_disable_voltage = (s_q.act == canopen_app_pkg::ACT_DISABLE_VOLTAGE);
    assign cmd_quick_stop = (s_q.act == canopen_app_pkg::ACT_QUICK_STOP)
        || (s_q.act == canopen_app_pkg::ACT_QSTOP_THEN_FAULT);
    assign cmd_disable_operation = (s_q.act == canopen_app_pkg::ACT_RAMP_THEN_FAULT);

    assign rxpdo_accept = rxpdo_valid
        && rxpdo_len_ok
        && !s_q.pdo_block;
    assign fault_reset_ok = fault_reset_req
        && !s_q.left_op
        && nmt_operational
        && !s_q.guard_lost;
    assign current_error = (s_q.err_code == canopen_app_pkg::ERR_GENERIC)
        ? s_q.cur_err : 16'h0000;
    assign emcy_fault_bytes = s_q.emcy;

endmodule : canopen_app_object_handler

// ### test/canopen_app_props.sv
// assertion checker for the application object handler
`timescale 1ns/1ps
module canopen_app_props (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic obj_wr,
    input wire logic [15:0] obj_index,
    input wire logic [15:0] obj_wdata,
    input wire logic [2:0] setting_value,
    input wire logic [9:0] src_select,
    input wire logic src_bool,
    input wire logic [15:0] demux_out,
    input wire logic [15:0] pct_set_out,
    input wire logic bus_off,
    input wire logic guarding_fail,
    input wire logic heartbeat_fail,
    input wire logic sync_error,
    input wire logic nmt_operational,
    input wire logic [1:0] local_remote,
    input wire logic drive_standstill,
    input wire logic cmd_fault,
    input wire logic cmd_disable_voltage,
    input wire logic cmd_quick_stop,
    input wire logic cmd_disable_operation,
    input wire logic fault_reset_ok,
    input wire logic fault_event,
    input wire logic [15:0] fault_code,
    input wire logic [31:0] emcy_fault_bytes
);
    // ------------------------------------------------------------
    // loss trigger and idle helpers
    // ------------------------------------------------------------
    logic nmt_q;
    logic trig;
    logic idle;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            nmt_q <= 1'b0;
        end else begin
            nmt_q <= nmt_operational;
        end
    end
    assign trig = bus_off | guarding_fail | heartbeat_fail | sync_error | (nmt_q & ~nmt_operational);
    assign idle = ~(cmd_fault | cmd_disable_voltage | cmd_quick_stop | cmd_disable_operation);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_loss;
        trig && idle;
    endsequence
    sequence s_remote(logic [2:0] code);
        s_loss ##0 (setting_value == code && local_remote == 2'h1);
    endsequence
    chk_demux_bit: assert property (src_select >= 10'h340 && src_select <= 10'h34F
        |-> src_bool == demux_out[src_select[3:0]]) else $error("demux bit wrong");
    chk_pct_set: assert property (obj_wr && obj_index == 16'h3006
        |=> pct_set_out == $past(obj_wdata)) else $error("set value not taken");
    chk_keep_point: assert property (s_loss ##0 setting_value == 3'h0 |=> idle)
        else $error("reaction with option 0");
    chk_fault_now: assert property (s_remote(3'h1) |=> cmd_fault)
        else $error("no fault on option 1");
    chk_volt_off: assert property (s_remote(3'h2) |=> cmd_disable_voltage && !cmd_fault)
        else $error("no disable voltage");
    chk_quick_stop: assert property (s_remote(3'h3) |=> cmd_quick_stop && !cmd_fault)
        else $error("no quick stop");
    chk_ramp_first: assert property (s_remote(3'h4) |=> cmd_disable_operation && !cmd_fault)
        else $error("ramp stop missing");
    chk_stop_fault: assert property (cmd_disable_operation && !cmd_fault && drive_standstill
        |=> cmd_fault) else $error("no fault at standstill");
    chk_remote_off: assert property (s_loss ##0 (setting_value != 3'h0 && local_remote != 2'h1)
        |=> cmd_fault) else $error("no fault in local mode");
    chk_reset_nmt: assert property (!nmt_operational |-> !fault_reset_ok)
        else $error("reset allowed off operational");
    chk_emcy_bytes: assert property (fault_event
        |=> emcy_fault_bytes == {$past(fault_code), 16'h0000}) else $error("emergency bytes wrong");
endmodule : canopen_app_props
bind canopen_app_object_handler canopen_app_props chk (.*);

// ### test/canopen_master_model.sv
// bus master model: raises link events and recovers the node
`timescale 1ns/1ps
module canopen_master_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ev_go,
    input wire logic [2:0] ev_sel,
    input wire logic recover,
    output logic bus_off,
    output logic guarding_fail,
    output logic heartbeat_fail,
    output logic sync_error,
    output logic nmt_operational,
    output logic guarding_running
);
    logic nmt_leave;
    assign nmt_leave = ev_go && ev_sel == 3'h4;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {bus_off, guarding_fail, heartbeat_fail, sync_error} <= 4'h0;
            {nmt_operational, guarding_running} <= 2'h0;
        end else begin
            bus_off <= ev_go && ev_sel == 3'h0;
            guarding_fail <= ev_go && ev_sel == 3'h1;
            heartbeat_fail <= ev_go && ev_sel == 3'h2;
            sync_error <= ev_go && ev_sel == 3'h3;
            nmt_operational <= nmt_leave ? 1'b0 : (recover | nmt_operational);
            guarding_running <= guarding_fail ? 1'b0 : (recover | guarding_running);
        end
    end
endmodule : canopen_master_model

// ### test/tb_canopen_app_object_handler.sv
// self-checking bench for the application object handler
`timescale 1ns/1ps
module tb_canopen_app_object_handler;
    logic sys_clk = 1'b0, rst = 1'b1, obj_wr = 1'b0, obj_rd = 1'b0, obj_ack, obj_err;
    logic [15:0] obj_index = 16'h0000, obj_wdata = 16'h0000, obj_rdata, r, d;
    logic setting_wr = 1'b0, save_cmd = 1'b0, nv_restore = 1'b0, nv_valid = 1'b0, nv_wr, e;
    logic [2:0] setting_wdata = 3'h0, setting_value, ev_sel = 3'h0;
    logic [15:0] nv_rdata = 16'h0000, nv_wdata, src_pct_value = 16'h0000, pct_set_out, demux_out;
    logic [9:0] src_select = 10'h000, pct_act_source_wdata = 10'h000, pct_src_req;
    logic pct_act_source_wr = 1'b0, src_bool, rxpdo_valid = 1'b0, rxpdo_len_ok = 1'b0;
    logic [7:0] modes_of_operation = 8'h00;
    logic [15:0] motion_block_number = 16'h0000, fault_code = 16'h0000, current_error;
    logic bus_off, guarding_fail, heartbeat_fail, sync_error, nmt_operational, guarding_running;
    logic [1:0] local_remote = 2'h1;
    logic drive_standstill = 1'b0, fault_reset_req = 1'b0, fault_event = 1'b0, ev_go = 1'b0;
    logic cmd_fault, cmd_disable_voltage, cmd_quick_stop, cmd_disable_operation;
    logic rxpdo_accept, fault_reset_ok, recover = 1'b0;
    logic [3:0] fault_class = 4'h0, cmds;
    logic [31:0] emcy_fault_bytes;
    logic [15:0] codes[6] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'hFFFF, 16'hFFFE};
    logic [3:0] xcmd[4] = '{4'h0, 4'h8, 4'h4, 4'h2};
    logic [3:0] cls[9] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'hD, 4'h6};
    logic [15:0] errs[9] = '{16'h2310, 16'h4210, 16'h4110, 16'h4310, 16'h2340,
        16'h3210, 16'h5111, 16'h2330, 16'h1000};
    int n_fail = 0;
    int checks = 0;
    assign cmds = {cmd_fault, cmd_disable_voltage, cmd_quick_stop, cmd_disable_operation};
    canopen_app_object_handler uut (.*);
    canopen_master_model mst (.*);
    always #20 sys_clk = ~sys_clk;
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task cmp(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: exp %h got %h", $time, exp, got);
        end
    endtask : cmp
    task automatic pulse(ref logic s);
        @(negedge sys_clk);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask : pulse
    task acc(input logic w, input logic [15:0] idx, input logic [15:0] wd);
        @(negedge sys_clk);
        {obj_wr, obj_rd, obj_index, obj_wdata} = {w, ~w, idx, wd};
        @(negedge sys_clk);
        {obj_wr, obj_rd} = 2'b00;
        cmp(32'h1, {31'h0, obj_ack});
        {e, r} = {obj_err, obj_rdata};
    endtask : acc
    task ev(input logic [2:0] sel);
        ev_sel = sel;
        pulse(ev_go);
        repeat (2) @(negedge sys_clk);
    endtask : ev
    task rec();
        pulse(recover);
        @(negedge sys_clk);
        fault_reset_req = 1'b1;
        #1;
        cmp(32'h1, {31'h0, fault_reset_ok});
        @(negedge sys_clk);
        fault_reset_req = 1'b0;
        @(negedge sys_clk);
        cmp(32'h0, {28'h0, cmds});
    endtask : rec
    task test_done();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    initial begin
        void'($urandom(32'h6B87));
        repeat (20) @(negedge sys_clk);
        rst = 1'b0;
        pulse(recover);
        cmp(32'h1, {29'h0, setting_value});
        cmp(32'h34, {22'h0, pct_src_req});
        acc(1'b0, canopen_app_pkg::IDX_ERROR_CODE, 16'h0000);
        cmp(32'h0, {16'h0, r});
        d = 16'($urandom);
        acc(1'b1, canopen_app_pkg::IDX_DEMUX, d);
        cmp({16'h0, d}, {16'h0, demux_out});
        acc(1'b0, canopen_app_pkg::IDX_DEMUX, 16'h0000);
        cmp({16'h0, d}, {16'h0, r});
        for (int s = 830; s < 850; s++) begin
            @(negedge sys_clk);
            src_select = 10'(s);
            #1;
            cmp((s >= 832 && s <= 847) ? {31'h0, d[s - 832]} : 32'h0, {31'h0, src_bool});
        end
        acc(1'b1, canopen_app_pkg::IDX_PCT_SET, 16'h162E);
        cmp(32'h162E, {16'h0, pct_set_out});
        src_pct_value = 16'($urandom);
        pct_act_source_wdata = 10'h32F;
        pulse(pct_act_source_wr);
        cmp(32'h32F, {22'h0, pct_src_req});
        acc(1'b0, canopen_app_pkg::IDX_PCT_ACT, 16'h0000);
        cmp({16'h0, src_pct_value}, {16'h0, r});
        motion_block_number = 16'($urandom);
        acc(1'b0, canopen_app_pkg::IDX_MOTION_BLOCK, 16'h0000);
        cmp(32'h1, {31'h0, e});
        modes_of_operation = 8'hFF;
        acc(1'b0, canopen_app_pkg::IDX_MOTION_BLOCK, 16'h0000);
        cmp({16'h0, motion_block_number}, {15'h0, e, r});
        $display("test objects done");
        for (int i = 0; i < 6; i++) begin
            setting_wdata = 3'(i);
            pulse(setting_wr);
            acc(1'b0, canopen_app_pkg::IDX_ABORT_OPT, 16'h0000);
            cmp({16'h0, codes[i]}, {15'h0, e, r});
            acc(1'b1, canopen_app_pkg::IDX_ABORT_OPT, codes[(i + 1) % 6]);
            cmp(32'((i + 1) % 6), {29'h0, setting_value});
        end
        acc(1'b1, canopen_app_pkg::IDX_ABORT_OPT, 16'h0004);
        cmp(32'h1, {31'h0, e});
        $display("test option map done");
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, canopen_app_pkg::IDX_ABORT_OPT, codes[k]);
            ev(3'(k));
            cmp({28'h0, xcmd[k]}, {28'h0, cmds});
            rec();
        end
        acc(1'b1, canopen_app_pkg::IDX_ABORT_OPT, 16'h0001);
        ev(3'h4);
        pulse(fault_reset_req);
        cmp(32'h8, {28'h0, cmds});
        rec();
        ev(3'h1);
        pulse(fault_reset_req);
        cmp(32'h8, {28'h0, cmds});
        rec();
        for (int k = 4; k < 6; k++) begin
            acc(1'b1, canopen_app_pkg::IDX_ABORT_OPT, codes[k]);
            ev(3'h0);
            cmp(k == 4 ? 32'h1 : 32'h2, {28'h0, cmds});
            drive_standstill = 1'b1;
            repeat (2) @(negedge sys_clk);
            cmp(32'h1, {31'h0, cmd_fault});
            rec();
            drive_standstill = 1'b0;
        end
        local_remote = 2'h0;
        acc(1'b1, canopen_app_pkg::IDX_ABORT_OPT, 16'h0002);
        ev(3'h2);
        cmp(32'h8, {28'h0, cmds});
        rec();
        local_remote = 2'h1;
        $display("test loss reaction done");
        acc(1'b1, canopen_app_pkg::IDX_ABORT_OPT, 16'h0000);
        rxpdo_valid = 1'b1;
        #1;
        cmp(32'h0, {31'h0, rxpdo_accept});
        @(negedge sys_clk);
        rxpdo_len_ok = 1'b1;
        #1;
        cmp(32'h0, {31'h0, rxpdo_accept});
        repeat (2) @(negedge sys_clk);
        cmp(32'h1, {31'h0, rxpdo_accept});
        {rxpdo_valid, rxpdo_len_ok} = 2'b00;
        rec();
        acc(1'b1, canopen_app_pkg::IDX_ABORT_OPT, 16'hFFFE);
        pulse(save_cmd);
        for (int i = 0; i < 4 && nv_wr !== 1'b1; i++) @(negedge sys_clk);
        cmp(32'h1FFFE, {15'h0, nv_wr, nv_wdata});
        rst = 1'b1;
        @(negedge sys_clk);
        rst = 1'b0;
        cmp(32'h1, {29'h0, setting_value});
        {nv_valid, nv_rdata} = {1'b1, 16'hFFFE};
        pulse(nv_restore);
        nv_valid = 1'b0;
        cmp(32'h5, {29'h0, setting_value});
        pulse(recover);
        $display("test store done");
        for (int k = 0; k < 9; k++) begin
            {fault_class, fault_code} = {cls[k], 16'($urandom)};
            pulse(fault_event);
            acc(1'b0, canopen_app_pkg::IDX_ERROR_CODE, 16'h0000);
            cmp({16'h0, errs[k]}, {16'h0, r});
            cmp(k == 8 ? {16'h0, fault_code} : 32'h0, {16'h0, current_error});
            cmp({fault_code, 16'h0000}, emcy_fault_bytes);
        end
        $display("test faults done");
        test_done();
    end
endmodule : tb_canopen_app_object_handler
